// *** inc/imc_cfg.svh ***
`ifndef IMC_CFG_SVH
`define IMC_CFG_SVH
// Register byte offsets
`define IMC_ADDR_CTRL 8'h00
`define IMC_ADDR_MODE 8'h04
`define IMC_ADDR_XFER 8'h08
`define IMC_ADDR_DATA 8'h0C
`define IMC_ADDR_STAT 8'h10
// Control register low half fields
`define IMC_CTRL_SDA_MON 5
`define IMC_CTRL_RSV4 4
`define IMC_CTRL_SCL_MON 3
`define IMC_CTRL_RSV2 2
`define IMC_CTRL_RST 1
`define IMC_CTRL_RSV0 0
// Bus-mode register fields
`define IMC_MODE_RSV7 7
`define IMC_MODE_WAIT 6
`define IMC_MODE_RSV5 5
`define IMC_MODE_RSV4 4
`define IMC_MODE_WP 3
`define IMC_BITCOUNT_RST 3'h0
// Transfer and status fields
`define IMC_XFER_START 0
`define IMC_XFER_MASTER 1
`define IMC_STAT_BUSY 0
`define IMC_STAT_DONE 1
`define IMC_STAT_ACK 2
// Timing
`define IMC_CLK_PERIOD_NS 40
`define IMC_HALF_BIT_NS 5000
`define IMC_HALF_BIT_CYC ((`IMC_HALF_BIT_NS + `IMC_CLK_PERIOD_NS - 1) / `IMC_CLK_PERIOD_NS)
`define IMC_WAIT_TICKS 3'h4
`endif

// *** inc/imc_pkg.sv ***
package imc_pkg;
   // Frame engine states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LOW,
      ST_HIGH,
      ST_HOLD,
      ST_SLAVE
   } imc_state_e;

   // Bit-count code to frame length, acknowledge bit included
   function automatic logic [3:0] frame_bits(input logic [2:0] code);
      if (code == 3'h0) begin
         frame_bits = 4'h9;
      end else begin
         frame_bits = {1'b0, code} + 4'h1;
      end
   endfunction
endpackage

// *** design/imc_frame_engine.sv ***
`include "imc_cfg.svh"

module imc_frame_engine (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic start,
   input wire logic master,
   input wire logic wait_en,
   input wire logic [3:0] frame_len,
   input wire logic [8:0] tx_frame,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_level,
   output logic sda_level,
   output logic busy,
   output logic done,
   output logic [8:0] rx_frame
);
   imc_pkg::imc_state_e state;
   logic [3:0] bit_idx;
   logic [3:0] len;
   logic [2:0] wait_cnt;
   logic [8:0] tx_sh;
   logic scl_prev;
   logic last_bit;
   logic ack_next;
   logic scl_rise;

   assign last_bit = bit_idx == (len - 4'h1);
   assign ack_next = (bit_idx + 4'h1) == (len - 4'h1);
   assign scl_rise = scl_in & ~scl_prev;

   // Bit sequencing; slave frames follow the remote clock edges
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= imc_pkg::ST_IDLE;
      end else begin
         unique case (state)
            imc_pkg::ST_IDLE: if (start) begin
               state <= master ? imc_pkg::ST_LOW : imc_pkg::ST_SLAVE;
            end
            imc_pkg::ST_LOW: if (tick) begin
               state <= imc_pkg::ST_HIGH;
            end
            imc_pkg::ST_HIGH: if (tick) begin
               if (last_bit) begin
                  state <= imc_pkg::ST_IDLE;
               end else if (ack_next && wait_en) begin
                  state <= imc_pkg::ST_HOLD;
               end else begin
                  state <= imc_pkg::ST_LOW;
               end
            end
            imc_pkg::ST_HOLD: if (tick && wait_cnt == `IMC_WAIT_TICKS - 3'h1) begin
               state <= imc_pkg::ST_LOW;
            end
            imc_pkg::ST_SLAVE: if (scl_rise && last_bit) begin
               state <= imc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Extra low time counted in half-bit ticks
   always_ff @(posedge clk) begin
      if (!rst_n || state != imc_pkg::ST_HOLD) begin
         wait_cnt <= 3'h0;
      end else if (tick) begin
         wait_cnt <= wait_cnt + 3'h1;
      end
   end

   // Bit index, shifters and the end-of-frame pulse
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bit_idx <= 4'h0;
         len <= 4'h9;
         tx_sh <= 9'h1FF;
         rx_frame <= 9'h000;
         scl_prev <= 1'b1;
         done <= 1'b0;
      end else begin
         scl_prev <= scl_in;
         done <= ((state == imc_pkg::ST_HIGH) && tick && last_bit) ||
                 ((state == imc_pkg::ST_SLAVE) && scl_rise && last_bit);
         if (state == imc_pkg::ST_IDLE && start) begin
            bit_idx <= 4'h0;
            len <= frame_len;
            tx_sh <= tx_frame;
         end else if ((state == imc_pkg::ST_HIGH && tick) ||
                      (state == imc_pkg::ST_SLAVE && scl_rise)) begin
            bit_idx <= bit_idx + 4'h1;
            tx_sh <= {tx_sh[7:0], 1'b1};
            rx_frame <= {rx_frame[7:0], sda_in};
         end
      end
   end

   // Line levels; the acknowledge bit is released by a master, pulled by a slave
   always_comb begin
      scl_level = !(state == imc_pkg::ST_LOW || state == imc_pkg::ST_HOLD);
      if (state == imc_pkg::ST_SLAVE) begin
         sda_level = !last_bit;
      end else if (state == imc_pkg::ST_IDLE) begin
         sda_level = 1'b1;
      end else begin
         sda_level = last_bit | tx_sh[8];
      end
   end

   assign busy = state != imc_pkg::ST_IDLE;
endmodule

// *** design/imc_top.sv ***
// Operation
// - SCL monitor bit reads 1 while SCL is released by this side, 0 while this side drives it low.
// - Control register bit 2 always reads 0.
// - Writing 1 to reset bit resets protocol logic and clears the received data; other registers keep contents.
// - Control register bit 0 always reads 1.
// - Master with wait bit set holds SCL low two transfer clocks before ack.
// - Wait bit clear sends data and ack bits back to back.
// - Wait bit has no effect in slave mode.
// - Bus-mode bits 5 and 4 always read 1.
// - Bit-count field updates only when the same write has protect bit 0.
// - Protect bit is not stored and always reads 1.
// - Bit-count code 000 gives 9 bits, 001 to 111 give 2 to 8.
// - Bit-count field returns to 000 when a frame with ack completes.
// - Protocol reset needs no port setup or register reload by software.
`include "imc_cfg.svh"

module imc_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   // Response codes and the last count of the half-bit divider
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] HALF_LAST = 8'(`IMC_HALF_BIT_CYC - 1);

   // Software-visible state
   logic ctrl_logic_reset;
   logic mode_rsv7;
   logic wait_en;
   logic [2:0] bitcount;
   logic master_mode;
   logic [7:0] tx_byte;
   logic frame_done;

   // Bus capture
   logic [7:0] waddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic wr_go;
   logic wr_ok;
   logic [31:0] rd_word;
   logic rd_ok;

   // Protocol side
   logic eng_rst_n;
   logic [7:0] half_cnt;
   logic tick;
   logic start_pulse;
   logic scl_meta;
   logic scl_sync;
   logic sda_meta;
   logic sda_sync;
   logic eng_scl_level;
   logic eng_sda_level;
   logic eng_busy;
   logic eng_done;
   logic [8:0] rx_frame;

   // Write strobes per register, low byte lane only
   logic wr_ctrl;
   logic wr_mode;
   logic wr_xfer;
   logic wr_stat;
   logic wr_data;

   // Protocol logic is held in reset by the bit; registers are not touched
   assign eng_rst_n = aresetn & ~ctrl_logic_reset;

   // Address decode of the captured write
   always_comb begin
      wr_ok = (waddr == `IMC_ADDR_CTRL) || (waddr == `IMC_ADDR_MODE) ||
              (waddr == `IMC_ADDR_XFER) || (waddr == `IMC_ADDR_DATA) ||
              (waddr == `IMC_ADDR_STAT);
   end

   // Commit strobe: both halves captured and no response still pending
   assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_ctrl = wr_go && wstrb[0] && waddr == `IMC_ADDR_CTRL;
   assign wr_mode = wr_go && wstrb[0] && waddr == `IMC_ADDR_MODE;
   assign wr_xfer = wr_go && wstrb[0] && waddr == `IMC_ADDR_XFER;
   assign wr_data = wr_go && wstrb[0] && waddr == `IMC_ADDR_DATA;
   assign wr_stat = wr_go && wstrb[0] && waddr == `IMC_ADDR_STAT;

   // Write address channel; one slot, freed when the response is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         waddr <= 8'h00;
      end else if (s_axi_awready && s_axi_awvalid) begin
         s_axi_awready <= 1'b0;
         waddr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   // Write data channel; may arrive before or after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         wdata <= 32'h0000_0000;
         wstrb <= 4'h0;
      end else if (s_axi_wready && s_axi_wvalid) begin
         s_axi_wready <= 1'b0;
         wdata <= s_axi_wdata;
         wstrb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Write response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control low half: only the protocol reset bit is stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_logic_reset <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_logic_reset <= wdata[`IMC_CTRL_RST];
      end
   end

   // Bus-mode register; bit 7 is kept as written, software keeps it 0
   // Bit 7 has no function; storing it only makes the read-back match the write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_rsv7 <= 1'b0;
         wait_en <= 1'b0;
      end else if (wr_mode) begin
         mode_rsv7 <= wdata[`IMC_MODE_RSV7];
         wait_en <= wdata[`IMC_MODE_WAIT];
      end
   end

   // Bit count: frame end clears it, and wins over a write in the same cycle
   // A write in that last cycle is lost, so software must write between frames
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bitcount <= `IMC_BITCOUNT_RST;
      end else if (eng_done) begin
         bitcount <= `IMC_BITCOUNT_RST;
      end else if (wr_mode && !wdata[`IMC_MODE_WP]) begin
         bitcount <= wdata[2:0];
      end
   end

   // Transfer control and transmit byte
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         master_mode <= 1'b0;
         tx_byte <= 8'hFF;
      end else begin
         if (wr_xfer) begin
            master_mode <= wdata[`IMC_XFER_MASTER];
         end
         if (wr_data) begin
            tx_byte <= wdata[7:0];
         end
      end
   end

   // Start request is a single pulse; dropped while the logic is held in reset
   always_ff @(posedge aclk) begin
      if (!eng_rst_n) begin
         start_pulse <= 1'b0;
      end else begin
         start_pulse <= wr_xfer && wdata[`IMC_XFER_START] && !eng_busy;
      end
   end

   // Sticky frame-done flag; a new completion beats a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_done <= 1'b0;
      end else if (eng_done) begin
         frame_done <= 1'b1;
      end else if (wr_stat && wdata[`IMC_STAT_DONE]) begin
         frame_done <= 1'b0;
      end
   end

   // Read mux; fixed reserved values are built in here, not stored
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         `IMC_ADDR_CTRL: begin
            rd_word[`IMC_CTRL_SDA_MON] = ~sda_oe;
            rd_word[`IMC_CTRL_RSV4] = 1'b1;
            rd_word[`IMC_CTRL_SCL_MON] = ~scl_oe;
            rd_word[`IMC_CTRL_RSV2] = 1'b0;
            rd_word[`IMC_CTRL_RST] = ctrl_logic_reset;
            rd_word[`IMC_CTRL_RSV0] = 1'b1;
         end
         `IMC_ADDR_MODE: begin
            rd_word[`IMC_MODE_RSV7] = mode_rsv7;
            rd_word[`IMC_MODE_WAIT] = wait_en;
            rd_word[`IMC_MODE_RSV5] = 1'b1;
            rd_word[`IMC_MODE_RSV4] = 1'b1;
            rd_word[`IMC_MODE_WP] = 1'b1;
            rd_word[2:0] = bitcount;
         end
         `IMC_ADDR_XFER: begin
            rd_word[`IMC_XFER_MASTER] = master_mode;
         end
         `IMC_ADDR_DATA: begin
            rd_word[8:0] = rx_frame;
         end
         `IMC_ADDR_STAT: begin
            rd_word[`IMC_STAT_BUSY] = eng_busy;
            rd_word[`IMC_STAT_DONE] = frame_done;
            rd_word[`IMC_STAT_ACK] = rx_frame[0];
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   // Read channel; data is captured at the address handshake
   // The word is frozen then, so a monitor bit shows the drive of that cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arready && s_axi_arvalid) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Half-bit tick divider; part of the protocol logic, so it restarts too
   // It runs free, so the first low half of a master frame may be short
   always_ff @(posedge aclk) begin
      if (!eng_rst_n) begin
         half_cnt <= 8'h00;
         tick <= 1'b0;
      end else if (half_cnt == HALF_LAST) begin
         half_cnt <= 8'h00;
         tick <= 1'b1;
      end else begin
         half_cnt <= half_cnt + 8'h01;
         tick <= 1'b0;
      end
   end

   // Pin synchronisers; the first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end else begin
         scl_meta <= scl_i;
         scl_sync <= scl_meta;
         sda_meta <= sda_i;
         sda_sync <= sda_meta;
      end
   end

   // Frame engine; it sees only synchronised pin levels
   imc_frame_engine u_engine (
      .clk(aclk),
      .rst_n(eng_rst_n),
      .tick(tick),
      .start(start_pulse),
      .master(master_mode),
      .wait_en(wait_en & master_mode),
      .frame_len(imc_pkg::frame_bits(bitcount)),
      .tx_frame({tx_byte, 1'b1}),
      .scl_in(scl_sync),
      .sda_in(sda_sync),
      .scl_level(eng_scl_level),
      .sda_level(eng_sda_level),
      .busy(eng_busy),
      .done(eng_done),
      .rx_frame(rx_frame)
   );

   // Open-drain drivers; the protocol reset releases both lines at once
   // Registered, so the pins lag the engine by one clock
   always_ff @(posedge aclk) begin
      if (!eng_rst_n) begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         scl_oe <= ~eng_scl_level;
         sda_oe <= ~eng_sda_level;
      end
   end

   // Output data of the open-drain pins is always low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
      end
   end
endmodule

// *** tb/imc_checker_properties.sv ***
`include "imc_cfg.svh"

module imc_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scl_oe,
   input wire logic sda_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LOW_MAX = 625;
   logic [7:0] wr_addr;
   logic wr_rst;
   logic ctrl_rst_q;
   logic [9:0] low_cnt;
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Remember the write target so the commit edge can be decoded
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_addr <= 8'h00;
         wr_rst <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) wr_addr <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) wr_rst <= s_axi_wdata[1];
      end
   end

   // Reset bit as last committed; one cycle late, so the engine has settled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_rst_q <= 1'b0;
      end else if ($rose(s_axi_bvalid) && wr_addr == `IMC_ADDR_CTRL) begin
         ctrl_rst_q <= wr_rst;
      end
   end

   // Length of the current SCL low stretch, saturating
   always_ff @(posedge aclk) begin
      if (!aresetn || !scl_oe) low_cnt <= 10'h000;
      else if (low_cnt != 10'h3FF) low_cnt <= low_cnt + 10'h001;
   end

   ctrl_fixed_a: assert property (
      ar_hs && s_axi_araddr == `IMC_ADDR_CTRL |=> !s_axi_rdata[2] && s_axi_rdata[0])
      else $error("control reserved bits wrong");
   scl_mon_a: assert property (
      ar_hs && s_axi_araddr == `IMC_ADDR_CTRL |=> s_axi_rdata[3] == !$past(scl_oe))
      else $error("SCL monitor does not follow drive");
   mode_fixed_a: assert property (
      ar_hs && s_axi_araddr == `IMC_ADDR_MODE |=> s_axi_rdata[5:3] == 3'h7)
      else $error("mode fixed bits not one");
   rst_hold_a: assert property (ctrl_rst_q |-> !scl_oe && !sda_oe)
      else $error("lines driven while held in reset");
   low_bound_a: assert property (low_cnt <= LOW_MAX)
      else $error("SCL low stretch too long");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   b_latency_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   cover property (ar_hs && s_axi_araddr == `IMC_ADDR_MODE);
   cover property (ctrl_rst_q);
   cover property (low_cnt == 10'h271);
endmodule

bind imc_top imc_checker chk (.*);

// *** tb/imc_bus_peer.sv ***
module imc_bus_peer (
   input wire logic aclk,
   input wire logic scl,
   input wire logic [3:0] nbits,
   input wire logic gen,
   input wire logic clear,
   output logic scl_pull,
   output logic sda_pull
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      cnt = 0;
   end
   // Clock one frame on request; SCL stands released between frames
   always @(posedge gen) begin
      repeat (nbits) begin
         repeat (100) @(posedge aclk);
         scl_pull <= 1'b1;
         repeat (100) @(posedge aclk);
         scl_pull <= 1'b0;
      end
   end
   // Frame start resynchronises the bit counter
   always @(posedge clear) begin
      cnt = 0;
      sda_pull = 1'b0;
   end
   // Acknowledge through the low phase of the last clock
   always @(negedge scl) sda_pull = (cnt == nbits - 1);
   // Release only after the master has had time to sample
   always @(posedge scl) begin
      cnt = cnt + 1;
      if (cnt == nbits) begin
         repeat (130) @(posedge aclk);
         sda_pull = 1'b0;
         cnt = 0;
      end
   end
endmodule

// *** tb/test_i2c_mode_and_recovery_control.sv ***
`include "imc_cfg.svh"

module test_i2c_mode_and_recovery_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
   logic peer_scl, peer_sda, peer_gen, peer_clr, scl_hold, slow_ready;
   logic [3:0] peer_bits;
   int n_errors, n_tests, cyc, pulses, low_run, max_low;

   // Open-drain wires with pull-ups
   assign scl_i = !scl_oe && !peer_scl && !scl_hold;
   assign sda_i = !sda_oe && !peer_sda;

   imc_top dut (.*);
   imc_bus_peer peer (.aclk(aclk), .scl(scl_i), .nbits(peer_bits), .gen(peer_gen),
      .clear(peer_clr), .scl_pull(peer_scl), .sda_pull(peer_sda));

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // SCL pulse count and longest low stretch, then the hang guard
   always @(posedge aclk) begin
      if (scl_oe) begin
         low_run++;
         if (low_run == 1) pulses++;
      end else begin
         if (low_run > max_low) max_low = low_run;
         low_run = 0;
      end
      cyc++;
      if (cyc == 80000) begin
         n_errors++;
         final_report;
      end
   end

   task automatic final_report;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !slow_ready;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      chk({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !slow_ready;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(d, ed);
      chk({30'h0, r}, {30'h0, er});
   endtask

   task automatic t_regs;
      rd(`IMC_ADDR_CTRL, 32'h39, 2'h0);
      rd(`IMC_ADDR_MODE, 32'h38, 2'h0);
      wr(`IMC_ADDR_MODE, 8'h45, 2'h0);
      rd(`IMC_ADDR_MODE, 32'h7D, 2'h0);
      wr(`IMC_ADDR_MODE, 8'h0A, 2'h0);
      rd(`IMC_ADDR_MODE, 32'h3D, 2'h0);
      wr(`IMC_ADDR_MODE, 8'h00, 2'h0);
      // Late ready on both response channels: the answer must stand until taken
      slow_ready = 1'b1;
      wr(8'h14, 8'h55, 2'h2);
      rd(8'h14, 32'h0, 2'h2);
      slow_ready = 1'b0;
   endtask

   // Polling interval is coarse; frames last hundreds of cycles or more
   task automatic t_frame(input logic [2:0] code, input logic wt, input logic mst);
      logic [3:0] len;
      logic [31:0] d;
      logic [1:0] r;
      len = (code == 3'h0) ? 4'h9 : {1'b0, code} + 4'h1;
      scl_hold <= 1'b1;
      wr(`IMC_ADDR_MODE, {1'b0, wt, 3'h0, code}, 2'h0);
      // SCL rises one clock before the peer clears, so that edge is not counted
      scl_hold <= 1'b0;
      @(posedge aclk);
      peer_bits <= len;
      peer_clr <= 1'b1;
      pulses = 0;
      max_low = 0;
      wr(`IMC_ADDR_XFER, {6'h00, mst, 1'b1}, 2'h0);
      peer_clr <= 1'b0;
      if (!mst) begin
         peer_gen <= 1'b1;
         @(posedge aclk);
         peer_gen <= 1'b0;
      end
      for (int i = 0; i < 400; i++) begin
         repeat (20) @(posedge aclk);
         axi_rd(`IMC_ADDR_STAT, d, r);
         if (d[`IMC_STAT_DONE]) break;
      end
      chk(pulses, mst ? len : 0);
      chk(max_low, mst ? (wt ? 625 : 125) : 0);
      rd(`IMC_ADDR_MODE, {24'h0, 1'b0, wt, 6'h38}, 2'h0);
      if (len == 4'h9) rd(`IMC_ADDR_DATA, 32'h1FE, 2'h0);
      wr(`IMC_ADDR_STAT, 8'h02, 2'h0);
   endtask

   task automatic t_ctrl_rst;
      wr(`IMC_ADDR_MODE, 8'h40, 2'h0);
      wr(`IMC_ADDR_XFER, 8'h03, 2'h0);
      repeat (600) @(posedge aclk);
      wr(`IMC_ADDR_CTRL, 8'h02, 2'h0);
      repeat (300) @(posedge aclk);
      chk({28'h0, scl_o, sda_o, scl_oe, sda_oe}, 32'h0);
      rd(`IMC_ADDR_CTRL, 32'h3B, 2'h0);
      rd(`IMC_ADDR_MODE, 32'h78, 2'h0);
      wr(`IMC_ADDR_CTRL, 8'h00, 2'h0);
      rd(`IMC_ADDR_CTRL, 32'h39, 2'h0);
      t_frame(3'h0, 1'b1, 1'b1);
   endtask

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_awprot = 3'h0;
      s_axi_arprot = 3'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {peer_gen, peer_clr} = 2'h0;
      // SCL held low by the far side until the first frame, so bit-count writes are legal
      scl_hold = 1'b1;
      slow_ready = 1'b0;
      peer_bits = 4'h9;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      for (int c = 0; c < 8; c++) t_frame(c[2:0], 1'b0, 1'b1);
      t_frame(3'h0, 1'b1, 1'b1);
      t_frame(3'h0, 1'b1, 1'b0);
      t_ctrl_rst;
      final_report;
   end
endmodule
